/* File: common/hcs_pkg.sv */
// package for the high-speed clock select and divider block
package hcs_pkg;

  // ********************************************
  // register selection and bit positions
  // ********************************************
  typedef enum logic [2:0]
  {
    HCS_REG_OSC_MODE = 3'b000,
    HCS_REG_MAIN_OSC_CTRL = 3'b001,
    HCS_REG_MAIN_CLK_MODE = 3'b010,
    HCS_REG_PROC_CLK_CTRL = 3'b011,
    HCS_REG_INT_OSC_MODE = 3'b100
  } hcs_reg_e;

  localparam int EXT_CLK_SEL_BIT = 7;
  localparam int PIN_OSC_MODE_BIT = 6;
  localparam int HS_STOP_BIT = 7;
  localparam int MAIN_SRC_SEL_BIT = 2;
  localparam int SPLIT_SEL_BIT = 0;
  localparam int CPU_SRC_SEL_BIT = 4;
  localparam int DIV_LSB = 0;
  localparam int INT_OSC_STOP_BIT = 0;
  localparam int INT_OSC_STABLE_BIT = 7;

  // ********************************************
  // divider codes and reset values
  // ********************************************
  localparam logic [2:0] DIV_CODE_MAX = 3'h4;
  localparam logic [2:0] DIV_CODE_RST = 3'h1;
  localparam int STAB_TICKS_DEF = 16;

  // control state held by the block
  typedef struct packed
  {
    logic ext_clk_input_sel;
    logic hs_pin_osc_mode;
    logic hs_sys_clk_stop;
    logic main_clk_source_sel;
    logic periph_main_split_sel;
    logic cpu_clk_source_sel;
    logic [2:0] cpu_div_sel;
    logic int_hs_osc_stop;
  } hcs_ctrl_s;

  localparam hcs_ctrl_s CTRL_RST = '{
    ext_clk_input_sel: 1'b0,
    hs_pin_osc_mode: 1'b0,
    hs_sys_clk_stop: 1'b1,
    main_clk_source_sel: 1'b0,
    periph_main_split_sel: 1'b0,
    cpu_clk_source_sel: 1'b0,
    cpu_div_sel: DIV_CODE_RST,
    int_hs_osc_stop: 1'b0
  };

  // use of the two high-speed pins
  typedef struct packed
  {
    logic x1_port_mode;
    logic x2_port_mode;
    logic x2_ext_clk_in;
  } hcs_pins_s;

endpackage : hcs_pkg

/* File: hdl/hcs_clock_ctrl.sv */
// high-speed clock source select, cpu divider and oscillator control
// Behaviour
// - both mode bits set: first pin general port, second pin external clock.
// - clearing stop bit enables external clock input in external mode.
// - source and split bits set: high-speed clock feeds main and peripherals.
// - main on high-speed clock forbids other peripheral clock sources.
// - cpu source bit zero: cpu takes divided main clock.
// - divider codes 0..4 give /1../16, reset /2; flash pin picks internal.
// - stop instruction enters stop mode, halting high-speed clock.
// - setting stop bit halts resonator or external clock input.
// - status bit reads 0 on internal clock, 1 on high-speed clock.
// - clearing internal oscillator stop bit restarts it.
// - stable flag sets once internal oscillator accuracy has settled.
// - after reset internal oscillator runs and feeds the cpu.
// - source bit zero: main and peripherals internal; source set, split zero: peripherals high-speed.
// - mode bits at bits 7 and 6 of oscillator mode register.
// - high-speed stop bit at bit 7 of main oscillator control.
// - source and split bits at bits 2 and 0 of main mode register.
// - main source bit accepts one change after reset, then locks.
`timescale 1ns/1ps

module hcs_clock_ctrl #(
  parameter int STAB_TICKS = hcs_pkg::STAB_TICKS_DEF
)
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic reg_wr,
  input wire hcs_pkg::hcs_reg_e reg_sel,
  input wire logic [7:0] reg_wdata,
  input wire logic flash_prog_mode_pin,
  input wire logic stop_instr,
  input wire logic stop_release,
  input wire logic int_hs_osc_clock,
  input wire logic sub_clk_tick,
  input wire logic resonator_in_pin,
  input wire logic resonator_out_pin,
  output hcs_pkg::hcs_ctrl_s ctrl,
  output hcs_pkg::hcs_pins_s pins,
  output logic hs_system_clock,
  output logic main_clk_en,
  output logic periph_clk_en,
  output logic cpu_clk_en,
  output logic cpu_clk_status,
  output logic int_hs_osc_stable,
  output logic stop_mode
);

  initial
  begin
    if (STAB_TICKS < 1 || STAB_TICKS > 65535)
      $error("STAB_TICKS out of range");
  end

  // ********************************************
  // control registers
  // ********************************************
  hcs_pkg::hcs_ctrl_s ctrl_reg;
  hcs_pkg::hcs_ctrl_s ctrl_next;
  logic src_locked_reg;
  logic stop_mode_reg;
  logic x1_q_reg;
  logic x2_q_reg;
  logic [15:0] stab_cnt_reg;
  logic stable_reg;
  logic [4:0] div_cnt_reg;
  logic [1:0] cpu_src_reg;
  logic [2:0] div_act_reg;
  logic main_hs_reg;
  logic periph_hs_reg;

  wire logic wr_osc = reg_wr && reg_sel == hcs_pkg::HCS_REG_OSC_MODE;
  wire logic wr_moc = reg_wr && reg_sel == hcs_pkg::HCS_REG_MAIN_OSC_CTRL;
  wire logic wr_mcm = reg_wr && reg_sel == hcs_pkg::HCS_REG_MAIN_CLK_MODE;
  wire logic wr_pcc = reg_wr && reg_sel == hcs_pkg::HCS_REG_PROC_CLK_CTRL;
  wire logic wr_rcm = reg_wr && reg_sel == hcs_pkg::HCS_REG_INT_OSC_MODE;
  wire logic [2:0] div_wr = reg_wdata[hcs_pkg::DIV_LSB +: 3];
  wire logic new_src = reg_wdata[hcs_pkg::MAIN_SRC_SEL_BIT];
  // a prohibited divider code is dropped, keeping the last legal ratio
  wire logic div_ok = div_wr <= hcs_pkg::DIV_CODE_MAX;
  wire logic src_change = wr_mcm && !src_locked_reg
                          && new_src != ctrl_reg.main_clk_source_sel;

  // field updates per register write
  always_comb
  begin
    ctrl_next = ctrl_reg;
    if (wr_osc)
    begin
      ctrl_next.ext_clk_input_sel = reg_wdata[hcs_pkg::EXT_CLK_SEL_BIT];
      ctrl_next.hs_pin_osc_mode = reg_wdata[hcs_pkg::PIN_OSC_MODE_BIT];
    end
    if (wr_moc)
      ctrl_next.hs_sys_clk_stop = reg_wdata[hcs_pkg::HS_STOP_BIT];
    if (wr_mcm)
      ctrl_next.periph_main_split_sel = reg_wdata[hcs_pkg::SPLIT_SEL_BIT];
    if (src_change)
      ctrl_next.main_clk_source_sel = new_src;
    if (wr_pcc)
    begin
      ctrl_next.cpu_clk_source_sel = reg_wdata[hcs_pkg::CPU_SRC_SEL_BIT];
      if (div_ok)
        ctrl_next.cpu_div_sel = div_wr;
    end
    if (wr_rcm)
      ctrl_next.int_hs_osc_stop = reg_wdata[hcs_pkg::INT_OSC_STOP_BIT];
  end

  // register state, reset values run internal osc only
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      ctrl_reg <= hcs_pkg::CTRL_RST;
      src_locked_reg <= 1'b0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      if (src_change)
        src_locked_reg <= 1'b1;
    end
  end

  // ********************************************
  // stop mode and oscillator sources
  // ********************************************
  // stop entry wins over a release arriving in the same cycle
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      stop_mode_reg <= 1'b0;
    else if (stop_instr)
      stop_mode_reg <= 1'b1;
    else if (stop_release)
      stop_mode_reg <= 1'b0;
  end

  // pin edge detectors, pins are synchronous to sys_clk
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      x1_q_reg <= 1'b0;
      x2_q_reg <= 1'b0;
    end
    else
    begin
      x1_q_reg <= resonator_in_pin;
      x2_q_reg <= resonator_out_pin;
    end
  end

  wire logic ext_mode = ctrl_reg.ext_clk_input_sel && ctrl_reg.hs_pin_osc_mode;
  wire logic osc_mode = !ctrl_reg.ext_clk_input_sel
                        && ctrl_reg.hs_pin_osc_mode;
  wire logic hs_gate = !ctrl_reg.hs_sys_clk_stop && !stop_mode_reg;
  wire logic x1_rise = resonator_in_pin && !x1_q_reg;
  wire logic x2_rise = resonator_out_pin && !x2_q_reg;
  // external mode samples the second pin, oscillation mode the first
  assign hs_system_clock = hs_gate && ((ext_mode && x2_rise)
                                       || (osc_mode && x1_rise));
  assign pins.x1_port_mode = !osc_mode;
  assign pins.x2_port_mode = !ctrl_reg.hs_pin_osc_mode;
  assign pins.x2_ext_clk_in = ext_mode;

  wire logic int_run = !ctrl_reg.int_hs_osc_stop && !stop_mode_reg;
  wire logic int_tick = int_run && int_hs_osc_clock;

  // accuracy settles after a count of ticks from each restart
  always_ff @(posedge sys_clk)
  begin
    if (reset || !int_run)
    begin
      stab_cnt_reg <= 16'h0000;
      stable_reg <= 1'b0;
    end
    else if (int_tick && !stable_reg)
    begin
      stab_cnt_reg <= stab_cnt_reg + 16'h0001;
      if (stab_cnt_reg == 16'(STAB_TICKS - 1))
        stable_reg <= 1'b1;
    end
  end

  // ********************************************
  // main, peripheral and cpu selection
  // ********************************************
  wire logic main_hs_sel = ctrl_reg.main_clk_source_sel
                           && ctrl_reg.periph_main_split_sel;
  wire logic periph_hs_sel = ctrl_reg.main_clk_source_sel;
  // a switch takes hold on a tick of the new source, so no pulse is cut
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      main_hs_reg <= 1'b0;
      periph_hs_reg <= 1'b0;
    end
    else
    begin
      if (main_hs_sel ? hs_system_clock : int_tick)
        main_hs_reg <= main_hs_sel;
      if (periph_hs_sel ? hs_system_clock : int_tick)
        periph_hs_reg <= periph_hs_sel;
    end
  end

  wire logic main_tick = main_hs_reg ? hs_system_clock : int_tick;
  assign main_clk_en = main_tick;
  assign periph_clk_en = periph_hs_reg ? hs_system_clock : int_tick;

  // cpu source: 0 main, 1 internal under flash pin, 2 subsystem clock
  wire logic [1:0] cpu_src_sel = ctrl_reg.cpu_clk_source_sel ? 2'h2 :
                                 flash_prog_mode_pin ? 2'h1 : 2'h0;
  wire logic src_tick = cpu_src_reg == 2'h2 ? sub_clk_tick :
                        cpu_src_reg == 2'h1 ? int_tick : main_tick;
  wire logic [4:0] div_last = 5'((5'h01 << div_act_reg) - 5'h01);
  wire logic div_wrap = src_tick && div_cnt_reg >= div_last;
  // idle boundary lets a new choice load when the old source is dead
  wire logic div_idle = div_cnt_reg == 5'h00 && !src_tick;

  // divider, with source and ratio reloaded only at a period boundary
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      div_cnt_reg <= 5'h00;
      cpu_src_reg <= 2'h0;
      div_act_reg <= hcs_pkg::DIV_CODE_RST;
    end
    else
    begin
      if (div_wrap)
        div_cnt_reg <= 5'h00;
      else if (src_tick)
        div_cnt_reg <= div_cnt_reg + 5'h01;
      if (div_wrap || div_idle)
      begin
        cpu_src_reg <= cpu_src_sel;
        div_act_reg <= ctrl_reg.cpu_div_sel;
      end
    end
  end

  assign cpu_clk_en = div_wrap;
  assign cpu_clk_status = cpu_src_reg == 2'h0 && main_hs_reg;
  assign ctrl = ctrl_reg;
  assign int_hs_osc_stable = stable_reg;
  assign stop_mode = stop_mode_reg;

  // ********************************************
  // checks
  // ********************************************
  sequence stop_write_s;
    wr_moc && reg_wdata[hcs_pkg::HS_STOP_BIT];
  endsequence

  sequence restart_s;
    wr_rcm && !reg_wdata[hcs_pkg::INT_OSC_STOP_BIT] && !stop_mode_reg;
  endsequence

  hs_stop_quiet_a: assert property (@(posedge sys_clk) disable iff (reset)
    stop_write_s |=> !hs_system_clock [*3])
    else $error("high-speed clock ticked after stop bit set");
  stop_mode_quiet_a: assert property (@(posedge sys_clk) disable iff (reset)
    stop_instr |=> (!hs_system_clock && !int_tick) [*2])
    else $error("clock ticked in stop mode");
  ext_pin_mode_a: assert property (@(posedge sys_clk) disable iff (reset)
    ext_mode |-> pins.x1_port_mode && pins.x2_ext_clk_in)
    else $error("external mode pin use wrong");
  ext_accept_a: assert property (@(posedge sys_clk) disable iff (reset)
    ext_mode && !ctrl_reg.hs_sys_clk_stop && !stop_mode_reg && x2_rise
    |-> hs_system_clock)
    else $error("external clock edge not accepted");
  periph_hs_a: assert property (@(posedge sys_clk) disable iff (reset)
    main_hs_reg |-> periph_hs_reg)
    else $error("peripheral clock not high-speed with main");
  int_main_a: assert property (@(posedge sys_clk) disable iff (reset)
    !ctrl_reg.main_clk_source_sel && int_tick |=> !main_hs_reg
    && !periph_hs_reg)
    else $error("internal clock not selected");
  src_lock_a: assert property (@(posedge sys_clk) disable iff (reset)
    src_locked_reg |=> $stable(ctrl_reg.main_clk_source_sel))
    else $error("locked source bit changed");
  stable_flag_a: assert property (@(posedge sys_clk) disable iff (reset)
    restart_s ##1 !stable_reg |-> ##[1:200] stable_reg || !int_run
    || !int_hs_osc_clock)
    else $error("stable flag late");
  div_reset_a: assert property (@(posedge sys_clk)
    reset |=> div_act_reg == hcs_pkg::DIV_CODE_RST
    && !cpu_clk_status && int_run)
    else $error("reset clock state wrong");
  div_legal_a: assert property (@(posedge sys_clk) disable iff (reset)
    ctrl_reg.cpu_div_sel <= hcs_pkg::DIV_CODE_MAX)
    else $error("prohibited divider code held");
  status_a: assert property (@(posedge sys_clk) disable iff (reset)
    cpu_clk_status |-> cpu_src_reg == 2'h0 && main_hs_reg)
    else $error("status disagrees with cpu source");

endmodule : hcs_clock_ctrl

/* File: test/hcs_ext_clk_model.sv */
// behavioural external clock source facing the high-speed pins
`timescale 1ns/1ps

module hcs_ext_clk_model
(
  input wire logic sys_clk,
  input wire logic slow,
  output logic resonator_in_pin,
  output logic resonator_out_pin
);
  // ********************************************
  // free-running source
  // ********************************************
  logic [2:0] phase_reg = 3'h0;

  // a real source never stops; gating it is the device's duty
  always_ff @(posedge sys_clk)
  begin
    phase_reg <= phase_reg + 3'h1;
  end

  // first pin is a port here: a level that changes every cycle
  assign resonator_in_pin = phase_reg[0];
  assign resonator_out_pin = slow ? phase_reg[2] : phase_reg[1];
endmodule : hcs_ext_clk_model

/* File: test/tb_hs_clock_select_and_divider.sv */
// self-checking bench for the high-speed clock control block
`timescale 1ns/1ps

module tb_hs_clock_select_and_divider;
  // ********************************************
  // signals and instances
  // ********************************************
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic reg_wr = 1'b0;
  hcs_pkg::hcs_reg_e reg_sel = hcs_pkg::HCS_REG_OSC_MODE;
  logic [7:0] reg_wdata = 8'h00;
  logic flash_pin = 1'b0;
  logic stop_instr = 1'b0;
  logic stop_release = 1'b0;
  logic slow = 1'b0;
  logic in_pin, out_pin, hs_clk, main_en, periph_en, cpu_en;
  logic status, stable, stop_mode;
  hcs_pkg::hcs_ctrl_s ctrl;
  hcs_pkg::hcs_pins_s pins;
  int bad_count = 0;
  int n_checks = 0;
  int m, p, c, h;

  // 125 MHz
  always #4 sys_clk = ~sys_clk;

  hcs_ext_clk_model src (.sys_clk(sys_clk), .slow(slow),
    .resonator_in_pin(in_pin), .resonator_out_pin(out_pin));

  // short settling count keeps the run brief
  hcs_clock_ctrl #(.STAB_TICKS(4)) uut (.sys_clk(sys_clk), .reset(reset),
    .reg_wr(reg_wr), .reg_sel(reg_sel), .reg_wdata(reg_wdata),
    .flash_prog_mode_pin(flash_pin), .stop_instr(stop_instr),
    .stop_release(stop_release), .int_hs_osc_clock(1'b1),
    .sub_clk_tick(1'b0), .resonator_in_pin(in_pin),
    .resonator_out_pin(out_pin), .ctrl(ctrl), .pins(pins),
    .hs_system_clock(hs_clk), .main_clk_en(main_en),
    .periph_clk_en(periph_en), .cpu_clk_en(cpu_en),
    .cpu_clk_status(status), .int_hs_osc_stable(stable),
    .stop_mode(stop_mode));

  // ********************************************
  // shared tasks
  // ********************************************
  task automatic check(input string name, input logic [31:0] seen,
    input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    if (bad_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  // a bound that ran out ends the run at once
  task automatic give_up(input int k);
    if (k >= 40)
    begin
      bad_count++;
      report_and_stop();
    end
  endtask : give_up

  task automatic write_reg(input hcs_pkg::hcs_reg_e sel, input logic [7:0] d);
    @(negedge sys_clk);
    reg_wr = 1'b1;
    reg_sel = sel;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask : write_reg

  // let a source switch land, then count pulses over 40 cycles
  task automatic count_pulses();
    {m, p, c, h} = '0;
    repeat (20) @(negedge sys_clk);
    repeat (40)
    begin
      @(negedge sys_clk);
      m += main_en;
      p += periph_en;
      c += cpu_en;
      h += hs_clk;
    end
  endtask : count_pulses

  task automatic pulse(input bit rel);
    @(negedge sys_clk);
    if (rel)
      stop_release = 1'b1;
    else
      stop_instr = 1'b1;
    @(negedge sys_clk);
    {stop_instr, stop_release} = 2'b00;
    @(negedge sys_clk);
  endtask : pulse

  task automatic wait_stable(output int k);
    k = 0;
    while (stable !== 1'b1 && k < 40)
    begin
      @(negedge sys_clk);
      k++;
    end
    give_up(k);
  endtask : wait_stable

  // ********************************************
  // scenarios
  // ********************************************
  task automatic test_reset();
    int k;
    check("ctrl", ctrl, hcs_pkg::CTRL_RST);
    check("pins", pins, 3'b110);
    check("status", status, 1'b0);
    count_pulses();
    check("main", m, 40);
    check("periph", p, 40);
    check("cpu", c, 20);
    check("hs", h, 0);
    wait_stable(k);
  endtask : test_reset

  task automatic test_int_osc();
    int k;
    write_reg(hcs_pkg::HCS_REG_INT_OSC_MODE, 8'h01);
    // the flag clears one edge after the stop bit itself lands
    @(negedge sys_clk);
    check("stable", stable, 1'b0);
    write_reg(hcs_pkg::HCS_REG_INT_OSC_MODE, 8'h00);
    wait_stable(k);
    check("settle", k > 1, 1'b1);
  endtask : test_int_osc

  task automatic test_divider();
    int gap;
    for (int code = 0; code < 6; code++)
    begin
      write_reg(hcs_pkg::HCS_REG_PROC_CLK_CTRL, 8'(code));
      repeat (40) @(negedge sys_clk);
      wait_stable(gap);
      gap = 0;
      while (cpu_en !== 1'b1 && gap < 40)
      begin
        @(negedge sys_clk);
        gap++;
      end
      give_up(gap);
      gap = 0;
      do
      begin
        @(negedge sys_clk);
        gap++;
      end
      while (cpu_en !== 1'b1 && gap < 40);
      give_up(gap);
      check("gap", gap, 1 << (code > 4 ? 4 : code));
    end
    check("div", ctrl.cpu_div_sel, 3'h4);
    write_reg(hcs_pkg::HCS_REG_PROC_CLK_CTRL, 8'h01);
  endtask : test_divider

  task automatic test_ext_clock();
    // mode bits move only while the high-speed clock is stopped
    write_reg(hcs_pkg::HCS_REG_OSC_MODE, 8'hC0);
    check("pins", pins, 3'b101);
    count_pulses();
    check("hs", h, 0);
    write_reg(hcs_pkg::HCS_REG_MAIN_OSC_CTRL, 8'h00);
    count_pulses();
    check("hs", h, 10);
    slow = 1'b1;
    count_pulses();
    check("hs slow", h, 5);
    slow = 1'b0;
  endtask : test_ext_clock

  task automatic test_main_select();
    // high-speed clock already runs before it is picked
    write_reg(hcs_pkg::HCS_REG_MAIN_CLK_MODE, 8'h05);
    count_pulses();
    check("status", status, 1'b1);
    check("main", m, 10);
    check("periph", p, 10);
    check("cpu", c, 5);
    flash_pin = 1'b1;
    count_pulses();
    check("cpu flash", c, 20);
    flash_pin = 1'b0;
    write_reg(hcs_pkg::HCS_REG_MAIN_CLK_MODE, 8'h01);
    check("src lock", ctrl.main_clk_source_sel, 1'b1);
    write_reg(hcs_pkg::HCS_REG_MAIN_CLK_MODE, 8'h04);
    count_pulses();
    check("main", m, 40);
    check("periph", p, 10);
    check("status", status, 1'b0);
  endtask : test_main_select

  task automatic test_stop();
    // peripherals idle and stabilisation time left as set
    pulse(1'b0);
    check("stop", stop_mode, 1'b1);
    count_pulses();
    check("hs", h, 0);
    check("stable", stable, 1'b0);
    pulse(1'b1);
    check("stop", stop_mode, 1'b0);
    count_pulses();
    check("hs", h, 10);
    // cpu is off the high-speed clock here, status reads 0
    write_reg(hcs_pkg::HCS_REG_MAIN_OSC_CTRL, 8'h80);
    count_pulses();
    check("hs", h, 0);
    check("periph", p, 0);
  endtask : test_stop

  // main sequence: synchronous reset for two cycles, then scenarios
  initial
  begin
    repeat (2) @(negedge sys_clk);
    reset = 1'b0;
    test_reset();
    test_int_osc();
    test_divider();
    test_ext_clock();
    test_main_select();
    test_stop();
    report_and_stop();
  end
endmodule : tb_hs_clock_select_and_divider
